// ==== src/pcad_pin.sv ====
module pcad_pin
  import pcad_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration
  input wire logic latch,
  input wire pcad_mode_t mode,
  input wire logic restrict_in_only,
  input wire logic restrict_i2c,
  input wire logic analog_dis,
  // Pin
  input wire logic pin_in,
  output logic pull_down,
  output logic pull_strong,
  output logic pull_weak,
  output logic pull_very_weak,
  // Filtered input
  output logic sensed
);
  logic sync1_reg, sync1_next;
  logic sync2_reg, sync2_next;
  logic filt_reg, filt_next;
  logic [1:0] gcnt_reg, gcnt_next;
  logic latch_q_reg, latch_q_next;
  logic [1:0] strong_reg, strong_next;
  pcad_mode_t eff_mode;

  always_comb
  begin
    eff_mode = mode;
    if (restrict_in_only)
    begin
      eff_mode = PCAD_MODE_INPUT_ONLY;
    end
    else if (restrict_i2c && !mode[1])
    begin
      eff_mode = PCAD_MODE_INPUT_ONLY;
    end
  end

  always_comb
  begin
    sync1_next = pin_in;
    sync2_next = sync1_reg;
    filt_next = filt_reg;
    gcnt_next = 2'h0;
    if (sync2_reg != filt_reg)
    begin
      gcnt_next = gcnt_reg + 2'h1;
      if (gcnt_reg == PCAD_GLITCH_CLKS - 2'h1)
      begin
        filt_next = sync2_reg;
        gcnt_next = 2'h0;
      end
    end
    latch_q_next = latch;
    strong_next = (strong_reg != 2'h0) ? strong_reg - 2'h1 : 2'h0;
    if (latch && !latch_q_reg)
    begin
      strong_next = PCAD_STRONG_CNT_INIT;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      filt_reg <= 1'b0;
      gcnt_reg <= 2'h0;
      latch_q_reg <= 1'b1;
      strong_reg <= 2'h0;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      filt_reg <= filt_next;
      gcnt_reg <= gcnt_next;
      latch_q_reg <= latch_q_next;
      strong_reg <= strong_next;
    end
  end

  always_comb
  begin
    pull_down = 1'b0;
    pull_strong = 1'b0;
    pull_weak = 1'b0;
    pull_very_weak = 1'b0;
    case (eff_mode)
      PCAD_MODE_QUASI:
      begin
        pull_down = !latch;
        pull_strong = latch && (strong_reg != 2'h0);
        pull_weak = latch && filt_reg;
        pull_very_weak = latch;
      end
      PCAD_MODE_PUSH_PULL:
      begin
        pull_down = !latch;
        pull_strong = latch;
      end
      PCAD_MODE_OPEN_DRAIN:
      begin
        pull_down = !latch;
      end
      PCAD_MODE_INPUT_ONLY:
      begin
        pull_down = 1'b0;
      end
      default:
      begin
        pull_down = 1'b0;
      end
    endcase
    sensed = analog_dis ? 1'b0 : filt_reg;
  end
endmodule

// ==== src/pcad_pkg.sv ====
package pcad_pkg;
  // Register word offsets (word addresses, Avalon word addressing by index)
  localparam logic [3:0] PCAD_IDX_P0_LATCH = 4'h0;
  localparam logic [3:0] PCAD_IDX_P1_LATCH = 4'h1;
  localparam logic [3:0] PCAD_IDX_P2_LATCH = 4'h2;
  localparam logic [3:0] PCAD_IDX_P3_LATCH = 4'h3;
  localparam logic [3:0] PCAD_IDX_P0_MODE_A = 4'h4;
  localparam logic [3:0] PCAD_IDX_P0_MODE_B = 4'h5;
  localparam logic [3:0] PCAD_IDX_P1_MODE_A = 4'h6;
  localparam logic [3:0] PCAD_IDX_P1_MODE_B = 4'h7;
  localparam logic [3:0] PCAD_IDX_P2_MODE_A = 4'h8;
  localparam logic [3:0] PCAD_IDX_P2_MODE_B = 4'h9;
  localparam logic [3:0] PCAD_IDX_P3_MODE_A = 4'hA;
  localparam logic [3:0] PCAD_IDX_P3_MODE_B = 4'hB;
  localparam logic [3:0] PCAD_IDX_ANALOG_DIS = 4'hC;
  localparam logic [3:0] PCAD_IDX_P0_PINS = 4'hD;
  localparam logic [3:0] PCAD_IDX_P1_PINS = 4'hE;
  localparam logic [3:0] PCAD_IDX_P2_PINS = 4'hF;
  localparam logic [3:0] PCAD_IDX_P3_PINS = 4'h0;
  localparam logic [4:0] PCAD_IDX_P3_PINS_FULL = 5'h10;
  // Reset values
  localparam logic [7:0] PCAD_RST_LATCH = 8'hFF;
  localparam logic [7:0] PCAD_RST_MODE_A = 8'hFF;
  localparam logic [7:0] PCAD_RST_MODE_B = 8'h00;
  localparam logic [7:0] PCAD_RST_ANALOG_DIS = 8'h00;
  // Writable analog-disable bits: port 0 pins one to five
  localparam logic [7:0] PCAD_ANALOG_DIS_MASK = 8'h3E;
  // Restricted pins (flat index = port*8 + pin)
  localparam int PCAD_RESET_SHARED_PIN = 13;
  localparam int PCAD_I2C_CLOCK_SHARED_PIN = 10;
  localparam int PCAD_I2C_DATA_SHARED_PIN = 11;
  localparam int PCAD_NUM_PINS = 26;
  // Strong pull-up pulse after a 0->1 latch change
  localparam int PCAD_STRONG_PULSE_CLKS = 2;
  localparam logic [1:0] PCAD_STRONG_CNT_INIT = 2'h2;
  // Glitch filter length in cycles
  localparam logic [1:0] PCAD_GLITCH_CLKS = 2'h2;

  typedef enum logic [1:0]
  {
    PCAD_MODE_QUASI = 2'b00,
    PCAD_MODE_PUSH_PULL = 2'b01,
    PCAD_MODE_INPUT_ONLY = 2'b10,
    PCAD_MODE_OPEN_DRAIN = 2'b11
  } pcad_mode_t;
endpackage

// ==== src/pcad_top.sv ====
// Function
// - A push-pull pin drives its strong pull-up continuously while its latch is one.
// - Quasi, push-pull and open-drain pins pull low whenever the latch is zero.
// - Pin inputs pass a glitch-suppressing filter before logic uses them.
// - The analog disable register holds bits one to five for port 0 pins one to five.
// - A set analog disable bit switches off that port 0 pin's digital input.
// - Port reads return zero for every pin whose digital input is disabled.
// - Any reset clears the analog disable bits so digital inputs are enabled.
// - After power-up every pin is input-only and high impedance.
// - The reset-shared pin stays input-only whatever its mode bits say.
// - The I2C-shared pins allow only input-only and open drain, never a pull-up.
// - Mode bits (a,b) select 00 quasi, 01 push-pull, 10 input-only, 11 open drain.
// - In quasi mode a latch change from zero to one enables the strong pull-up for two clocks.
// - Quasi weak pull-up needs latch and pin high; very weak pull-up follows the latch.
// - Open drain turns off all pull-ups and pulls low only for a zero latch.
//
// Register access over Avalon-MM and the address map were left to the implementer.
module pcad_top
  import pcad_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Avalon-MM slave, word address
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Pins, flat index port*8+pin, 26 pins
  input wire logic [25:0] PIN_IN,
  output logic [25:0] PIN_PULL_DOWN,
  output logic [25:0] PIN_PULL_STRONG,
  output logic [25:0] PIN_PULL_WEAK,
  output logic [25:0] PIN_PULL_VERY_WEAK,
  // Pin enables for output, low while driving
  output logic [25:0] PIN_OE_N
);
  logic rst_s1_reg, rst_s2_reg;
  logic rst_n_int;
  logic [25:0] latch_reg, latch_next;
  logic [25:0] mode_a_reg, mode_a_next;
  logic [25:0] mode_b_reg, mode_b_next;
  logic [7:0] analog_dis_reg, analog_dis_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic [25:0] sensed;
  logic [25:0] pd, ps, pw, pvw;
  logic wr_en;
  logic [7:0] wbyte;

  // Reset release through two flip-flops
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n_int = rst_s2_reg;

  // One wait cycle, then answer
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_reg;
  assign wr_en = AVS_WRITE && !ack_reg && AVS_BYTEENABLE[0];
  assign wbyte = AVS_WRITEDATA[7:0];

  function automatic logic [7:0] byte_of(input logic [25:0] v,
                                         input int port);
    logic [7:0] r;
    r = 8'h00;
    if (port == 3)
    begin
      r = {6'h00, v[25:24]};
    end
    else
    begin
      r = v[port*8 +: 8];
    end
    return r;
  endfunction

  always_comb
  begin
    latch_next = latch_reg;
    mode_a_next = mode_a_reg;
    mode_b_next = mode_b_reg;
    analog_dis_next = analog_dis_reg;
    if (wr_en)
    begin
      case (AVS_ADDRESS)
        {1'b0, PCAD_IDX_P0_LATCH}: latch_next[7:0] = wbyte;
        {1'b0, PCAD_IDX_P1_LATCH}: latch_next[15:8] = wbyte;
        {1'b0, PCAD_IDX_P2_LATCH}: latch_next[23:16] = wbyte;
        {1'b0, PCAD_IDX_P3_LATCH}: latch_next[25:24] = wbyte[1:0];
        {1'b0, PCAD_IDX_P0_MODE_A}: mode_a_next[7:0] = wbyte;
        {1'b0, PCAD_IDX_P0_MODE_B}: mode_b_next[7:0] = wbyte;
        {1'b0, PCAD_IDX_P1_MODE_A}: mode_a_next[15:8] = wbyte;
        {1'b0, PCAD_IDX_P1_MODE_B}: mode_b_next[15:8] = wbyte;
        {1'b0, PCAD_IDX_P2_MODE_A}: mode_a_next[23:16] = wbyte;
        {1'b0, PCAD_IDX_P2_MODE_B}: mode_b_next[23:16] = wbyte;
        {1'b0, PCAD_IDX_P3_MODE_A}: mode_a_next[25:24] = wbyte[1:0];
        {1'b0, PCAD_IDX_P3_MODE_B}: mode_b_next[25:24] = wbyte[1:0];
        {1'b0, PCAD_IDX_ANALOG_DIS}:
          analog_dis_next = wbyte & PCAD_ANALOG_DIS_MASK;
        default: latch_next = latch_reg;
      endcase
    end
  end

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    ack_next = (AVS_READ || AVS_WRITE) && !ack_reg;
    case (AVS_ADDRESS)
      {1'b0, PCAD_IDX_P0_LATCH}: rdata_next[7:0] = byte_of(latch_reg, 0);
      {1'b0, PCAD_IDX_P1_LATCH}: rdata_next[7:0] = byte_of(latch_reg, 1);
      {1'b0, PCAD_IDX_P2_LATCH}: rdata_next[7:0] = byte_of(latch_reg, 2);
      {1'b0, PCAD_IDX_P3_LATCH}: rdata_next[7:0] = byte_of(latch_reg, 3);
      {1'b0, PCAD_IDX_P0_MODE_A}: rdata_next[7:0] = byte_of(mode_a_reg, 0);
      {1'b0, PCAD_IDX_P0_MODE_B}: rdata_next[7:0] = byte_of(mode_b_reg, 0);
      {1'b0, PCAD_IDX_P1_MODE_A}: rdata_next[7:0] = byte_of(mode_a_reg, 1);
      {1'b0, PCAD_IDX_P1_MODE_B}: rdata_next[7:0] = byte_of(mode_b_reg, 1);
      {1'b0, PCAD_IDX_P2_MODE_A}: rdata_next[7:0] = byte_of(mode_a_reg, 2);
      {1'b0, PCAD_IDX_P2_MODE_B}: rdata_next[7:0] = byte_of(mode_b_reg, 2);
      {1'b0, PCAD_IDX_P3_MODE_A}: rdata_next[7:0] = byte_of(mode_a_reg, 3);
      {1'b0, PCAD_IDX_P3_MODE_B}: rdata_next[7:0] = byte_of(mode_b_reg, 3);
      {1'b0, PCAD_IDX_ANALOG_DIS}: rdata_next[7:0] = analog_dis_reg;
      {1'b0, PCAD_IDX_P0_PINS}: rdata_next[7:0] = byte_of(sensed, 0);
      {1'b0, PCAD_IDX_P1_PINS}: rdata_next[7:0] = byte_of(sensed, 1);
      {1'b0, PCAD_IDX_P2_PINS}: rdata_next[7:0] = byte_of(sensed, 2);
      PCAD_IDX_P3_PINS_FULL: rdata_next[7:0] = byte_of(sensed, 3);
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      latch_reg <= {PCAD_RST_LATCH[1:0], {3{PCAD_RST_LATCH}}};
      mode_a_reg <= {PCAD_RST_MODE_A[1:0], {3{PCAD_RST_MODE_A}}};
      mode_b_reg <= {PCAD_RST_MODE_B[1:0], {3{PCAD_RST_MODE_B}}};
      analog_dis_reg <= PCAD_RST_ANALOG_DIS;
      rdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
    end
    else
    begin
      latch_reg <= latch_next;
      mode_a_reg <= mode_a_next;
      mode_b_reg <= mode_b_next;
      analog_dis_reg <= analog_dis_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
    end
  end
  assign AVS_READDATA = rdata_reg;

  genvar gi;
  generate
    for (gi = 0; gi < PCAD_NUM_PINS; gi++)
    begin : g_pin
      pcad_pin u_pin (
        .clk(SYS_CLK),
        .rst_n(rst_n_int),
        .latch(latch_reg[gi]),
        .mode(pcad_mode_t'({mode_a_reg[gi], mode_b_reg[gi]})),
        .restrict_in_only(gi == PCAD_RESET_SHARED_PIN),
        .restrict_i2c(gi == PCAD_I2C_CLOCK_SHARED_PIN ||
                      gi == PCAD_I2C_DATA_SHARED_PIN),
        .analog_dis((gi < 8) ? analog_dis_reg[gi % 8] : 1'b0),
        .pin_in(PIN_IN[gi]),
        .pull_down(pd[gi]),
        .pull_strong(ps[gi]),
        .pull_weak(pw[gi]),
        .pull_very_weak(pvw[gi]),
        .sensed(sensed[gi])
      );
    end
  endgenerate

  assign PIN_PULL_DOWN = pd;
  assign PIN_PULL_STRONG = ps;
  assign PIN_PULL_WEAK = pw;
  assign PIN_PULL_VERY_WEAK = pvw;
  assign PIN_OE_N = ~(pd | ps);
endmodule

// ==== tb/pcad_pin_world.sv ====
module pcad_pin_world
(
  // Clock
  input wire logic clk,
  // Pin controls from the block
  input wire logic [25:0] pull_down,
  input wire logic [25:0] pull_up,
  // Outside drivers
  input wire logic [25:0] ext_en,
  input wire logic [25:0] ext_val,
  // Pin level
  output logic [25:0] level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [25:0] drift = 26'h0;
  // A floating pin wanders every cycle
  always @(posedge clk)
    drift <= ~drift;
  assign level = (ext_en & ext_val) |
    (~ext_en & ~pull_down & (pull_up | drift));
endmodule

// ==== tb/pcad_top_assertions.sv ====
module pcad_checker
  import pcad_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Bus
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Pins
  input wire logic [25:0] PIN_IN,
  input wire logic [25:0] PIN_PULL_DOWN,
  input wire logic [25:0] PIN_PULL_STRONG,
  input wire logic [25:0] PIN_PULL_WEAK,
  input wire logic [25:0] PIN_PULL_VERY_WEAK,
  input wire logic [25:0] PIN_OE_N
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] dis_reg;
  logic req;
  logic rd_ok;
  logic wr_ok;
  assign req = AVS_READ | AVS_WRITE;
  assign rd_ok = AVS_READ & ~AVS_WAITREQUEST;
  assign wr_ok = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
  // Shadow of the analog disable bits
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      dis_reg <= 8'h00;
    else if (wr_ok && AVS_ADDRESS == 5'h0C)
      dis_reg <= AVS_WRITEDATA[7:0] & PCAD_ANALOG_DIS_MASK;
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  a_first_wait: assert property (req && !$past(req) |-> AVS_WAITREQUEST)
    else $error("no wait cycle");
  a_one_wait: assert property ((req && AVS_WAITREQUEST) ##1 req
    |-> !AVS_WAITREQUEST) else $error("wait too long");
  a_dis_back: assert property (rd_ok && AVS_ADDRESS == 5'h0C
    |-> AVS_READDATA[7:0] == dis_reg) else $error("disable readback");
  a_dis_zero: assert property (rd_ok && AVS_ADDRESS == 5'h0D
    |-> (AVS_READDATA[7:0] & dis_reg) == 8'h00) else $error("disabled pin");
  a_i2c_nopull: assert property (((PIN_PULL_STRONG | PIN_PULL_WEAK |
    PIN_PULL_VERY_WEAK) & 26'h0000C00) == 26'h0) else $error("i2c pull-up");
  a_rst_pin: assert property ({PIN_PULL_DOWN[13], PIN_PULL_STRONG[13],
    PIN_PULL_WEAK[13], PIN_PULL_VERY_WEAK[13], !PIN_OE_N[13]} == 5'h0)
    else $error("reset pin active");
  a_drive_oe: assert property (PIN_OE_N ==
    ~(PIN_PULL_DOWN | PIN_PULL_STRONG)) else $error("enable mismatch");
  a_boot_idle: assert property ($rose(RST_N) |->
    (PIN_OE_N == 26'h3FFFFFF && PIN_PULL_VERY_WEAK == 26'h0)[*3])
    else $error("pins not idle");
  cover property (rd_ok && AVS_ADDRESS == 5'h0D && dis_reg != 8'h00);
  cover property ($rose(PIN_PULL_STRONG[16]));
  cover property (wr_ok && AVS_ADDRESS == 5'h0C);
endmodule

bind pcad_top pcad_checker u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .PIN_IN(PIN_IN), .PIN_PULL_DOWN(PIN_PULL_DOWN),
  .PIN_PULL_STRONG(PIN_PULL_STRONG), .PIN_PULL_WEAK(PIN_PULL_WEAK),
  .PIN_PULL_VERY_WEAK(PIN_PULL_VERY_WEAK), .PIN_OE_N(PIN_OE_N));

// ==== tb/tb_port_pin_config_analog_disable.sv ====
module tb_port_pin_config_analog_disable
  import pcad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, rd, wr, waitreq;
  logic [4:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [7:0] got;
  logic [25:0] pin, pd, ps, pw, pvw, oe_n, ext_en, ext_val;
  int n_errors, checked, strong_cnt;
  pcad_top DUT (.SYS_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .PIN_IN(pin), .PIN_PULL_DOWN(pd), .PIN_PULL_STRONG(ps),
    .PIN_PULL_WEAK(pw), .PIN_PULL_VERY_WEAK(pvw), .PIN_OE_N(oe_n));
  pcad_pin_world u_world (.clk(clk), .pull_down(pd),
    .pull_up(ps | pw | pvw), .ext_en(ext_en), .ext_val(ext_val),
    .level(pin));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
    if (ps[16] === 1'b1)
      strong_cnt++;
  task tally_and_finish;
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task acc(input bit w, input logic [4:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (waitreq !== 1'b0 && k < 20);
    got = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 20)
    begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  task rchk(input string nm, input logic [4:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(nm, {24'h0, got}, {24'h0, exp});
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    {rst_n, rd, wr, addr, wdata, ext_en, ext_val} = '0;
    be = 4'hF;
    n_errors = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("oe_n", oe_n, 32'h3FFFFFF);
    chk("pulls", pd | ps | pw | pvw, 32'h0);
    for (int i = 0; i < 13; i++)
      rchk("reset", i, (i == 12) ? 8'h00 :
        (i == 3 || i == 10) ? 8'h03 :
        (i < 4 || i % 2 == 0) ? 8'hFF : 8'h00);
    acc(1'b1, 5'h11, 8'hFF);
    rchk("unmapped", 5'h11, 8'h00);
    be <= 4'h0;
    acc(1'b1, 5'h0C, 8'hFF);
    be <= 4'hF;
    rchk("lane off", 5'h0C, 8'h00);
    acc(1'b1, 5'h0C, 8'hFF);
    rchk("disable", 5'h0C, 8'h3E);
    // Port 0 stays input-only while its inputs are off
    ext_en <= 26'h30000FF;
    ext_val <= 26'h10000FF;
    repeat (10) @(posedge clk);
    rchk("p0 off", 5'h0D, 8'hC1);
    rchk("p3 pins", 5'h10, 8'h01);
    acc(1'b1, 5'h0C, 8'h00);
    repeat (10) @(posedge clk);
    rchk("p0 on", 5'h0D, 8'hFF);
    ext_val <= 26'hFE;
    @(posedge clk);
    ext_val <= 26'hFF;
    rchk("glitch", 5'h0D, 8'hFF);
    // Port 2: quasi, push-pull, input-only, open drain
    acc(1'b1, 5'h02, 8'h00);
    acc(1'b1, 5'h08, 8'hFC);
    acc(1'b1, 5'h09, 8'h0A);
    repeat (2) @(posedge clk);
    chk("p2 down", pd[19:16], 32'hB);
    strong_cnt = 0;
    acc(1'b1, 5'h02, 8'hFF);
    repeat (10) @(posedge clk);
    chk("quasi pulse", strong_cnt, PCAD_STRONG_PULSE_CLKS);
    chk("p2 strong", ps[19:16], 32'h2);
    chk("p2 vweak", pvw[19:16], 32'h1);
    chk("p2 weak", pw[19:16], 32'h1);
    ext_en <= 26'h100FF;
    repeat (10) @(posedge clk);
    chk("weak off", {pw[16], pvw[16]}, 32'h1);
    // Port 1 push-pull, then open drain
    acc(1'b1, 5'h06, 8'h00);
    acc(1'b1, 5'h07, 8'hFF);
    repeat (2) @(posedge clk);
    chk("p1 strong", ps[15:8], 32'hD3);
    acc(1'b1, 5'h01, 8'h00);
    repeat (2) @(posedge clk);
    chk("p1 down", pd[15:8], 32'hD3);
    acc(1'b1, 5'h06, 8'hFF);
    repeat (2) @(posedge clk);
    chk("p1 od", pd[15:8], 32'hDF);
    // Reset in mid-run
    acc(1'b1, 5'h0C, 8'h3E);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("oe_n again", oe_n, 32'h3FFFFFF);
    rchk("disable again", 5'h0C, 8'h00);
    tally_and_finish();
  end
endmodule
